// >>> core/dacp_consts.svh
// register offsets, field positions, reset values and timing of the data port front end
`ifndef DACP_CONSTS_SVH
`define DACP_CONSTS_SVH

// register offsets
`define DACP_ADDR_MODE 8'h02
`define DACP_ADDR_LOCK 8'h04
`define DACP_ADDR_STAT 8'h06

// mode register fields
`define DACP_BIT_SINGLE 6
`define DACP_BIT_DATA_CLOCK_EXPORT 3
`define DACP_BIT_SYNC 2
`define DACP_BIT_IQ_SELECT_POLARITY 1
// lock register field
`define DACP_BIT_LOCKEXT 0

// status register fields
`define DACP_ST_LOCK 0
`define DACP_ST_OVF 1
`define DACP_ST_EMPTY 2
`define DACP_ST_FULL 3
`define DACP_ST_PIN_OUT 4

// reset values
`define DACP_RST_SINGLE 1'b0
`define DACP_RST_DATA_CLOCK_EXPORT 1'b0
`define DACP_RST_SYNC 1'b0
`define DACP_RST_IQ_SELECT_POLARITY 1'b0
`define DACP_RST_LOCKEXT 1'b0

// timing
`define DACP_REF_PERIOD_NS 50
`define DACP_DBL_HALF_NS 200

`endif

// >>> core/dacp_pkg.sv
// types shared by the data port front end
package dacp_pkg;
   typedef enum logic [1:0] {DACP_PIN_IN, DACP_PIN_CLK_OUT, DACP_PIN_LOCK_OUT} dacp_pin_mode_t;
   typedef enum logic {DACP_WAIT_I, DACP_WAIT_Q} dacp_pair_st_t;
endpackage

// >>> core/dacp_stream_if.sv
// valid/ready stream into and out of the sample fifo
`timescale 1ns/10ps
interface dacp_stream_if #(parameter int W = 32);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport src (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
   modport fifo (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface

// >>> core/dacp_fifo.sv
// sample pair fifo, flip-flop storage
`timescale 1ns/10ps
module dacp_fifo
   import dacp_pkg::*;
#(
   parameter int W = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // both stream sides
   dacp_stream_if.fifo s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLC = CW'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] cnt;
   logic do_wr;
   logic do_rd;

   assign s.in_ready = (cnt != FULLC);
   assign s.out_valid = (cnt != '0);
   assign s.out_data = mem[rd_ptr];
   assign do_wr = s.in_valid && s.in_ready;
   assign do_rd = s.out_valid && s.out_ready;

   always_ff @(posedge i_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= s.in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt <= cnt + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule

// >>> core/dacp_top.sv
// data port front end: shared clock/lock pin, port routing, sample fifo
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "dacp_consts.svh"
module dacp_top
   import dacp_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int DBL_HALF = `DACP_DBL_HALF_NS / `DACP_REF_PERIOD_NS
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // data ports
   input wire logic [15:0] I_PORT_ONE_BITS,
   input wire logic [13:0] I_PORT_TWO_LOW_BITS,
   input wire logic I_SHARED_IQ_SELECT_PIN,
   // shared clock / lock pin
   input wire logic I_SHARED_CLOCK_LOCK_PIN,
   output logic O_SHARED_CLOCK_LOCK_PIN,
   output logic O_SHARED_CLOCK_LOCK_PIN_OE,
   // shared double rate clock pin
   input wire logic I_SHARED_DOUBLE_RATE_CLOCK_PIN,
   output logic O_SHARED_DOUBLE_RATE_CLOCK_PIN,
   output logic O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE,
   // pll status
   input wire logic I_PLL_LOCK,
   // sample pair stream
   output logic [15:0] O_I_WORD,
   output logic [15:0] O_Q_WORD,
   output logic O_WORD_VALID,
   input wire logic I_WORD_READY
);
   localparam int SW = 34;
   localparam int CW = (DBL_HALF > 1) ? $clog2(DBL_HALF) : 1;
   localparam logic [CW-1:0] HALF_LAST = CW'(DBL_HALF - 1);

   // control bits
   logic single_port_mode;
   logic data_clock_export;
   logic clock_synchronizer_enable;
   logic iq_select_polarity;
   logic lock_status_export;
   logic overflow;

   // synchronised pins
   logic [SW-1:0] raw;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic [15:0] port_one_bits;
   logic [13:0] port_two_low_bits;
   logic iq_select_input;
   logic dbl_pin_in;
   logic clk_pin_in;
   logic lock_s;
   logic clk_pin_prev;
   logic pin_rise;

   // internal clock divider
   logic [CW-1:0] div_cnt;
   logic tick;
   logic dbl_int;
   logic dclk_int;
   logic dbl_rise;
   logic dclk_rise;

   // latch and pairing
   dacp_pin_mode_t pin_mode;
   dacp_pair_st_t pair_st;
   logic use_pin;
   logic int_ev;
   logic lat_ev;
   logic take;
   logic to_i;
   logic [15:0] i_hold;
   logic push_v;
   logic [15:0] push_i;
   logic [15:0] push_q;
   logic wr_stat_ovf;

   dacp_stream_if #(.W(32)) strm ();

   dacp_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
      .i_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .s(strm)
   );

   // every data port, shared pin and pll lock input passes two flops; data and clock share the same latency
   assign raw = {I_PLL_LOCK, I_SHARED_CLOCK_LOCK_PIN, I_SHARED_DOUBLE_RATE_CLOCK_PIN,
                 I_SHARED_IQ_SELECT_PIN, I_PORT_TWO_LOW_BITS, I_PORT_ONE_BITS};

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sync1 <= '0;
         sync2 <= '0;
         clk_pin_prev <= 1'b0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         clk_pin_prev <= clk_pin_in;
      end
   end

   assign port_one_bits = sync2[15:0];
   assign port_two_low_bits = sync2[29:16];
   assign iq_select_input = sync2[30];
   assign dbl_pin_in = sync2[31];
   assign clk_pin_in = sync2[32];
   assign lock_s = sync2[33];
   assign pin_rise = clk_pin_in && !clk_pin_prev;

   // register writes
   assign wr_stat_ovf = I_WR && (I_ADDR == `DACP_ADDR_STAT) && I_WDATA[`DACP_ST_OVF];

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         single_port_mode <= `DACP_RST_SINGLE;
         data_clock_export <= `DACP_RST_DATA_CLOCK_EXPORT;
         clock_synchronizer_enable <= `DACP_RST_SYNC;
         iq_select_polarity <= `DACP_RST_IQ_SELECT_POLARITY;
         lock_status_export <= `DACP_RST_LOCKEXT;
      end else if (I_WR) begin
         if (I_ADDR == `DACP_ADDR_MODE) begin
            single_port_mode <= I_WDATA[`DACP_BIT_SINGLE];
            data_clock_export <= I_WDATA[`DACP_BIT_DATA_CLOCK_EXPORT];
            clock_synchronizer_enable <= I_WDATA[`DACP_BIT_SYNC];
            iq_select_polarity <= I_WDATA[`DACP_BIT_IQ_SELECT_POLARITY];
         end
         if (I_ADDR == `DACP_ADDR_LOCK) begin
            lock_status_export <= I_WDATA[`DACP_BIT_LOCKEXT];
         end
      end
   end

   // sticky overflow; a new overflow beats a clear in the same cycle
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         overflow <= 1'b0;
      end else if (lat_ev && push_v) begin
         overflow <= 1'b1;
      end else if (wr_stat_ovf) begin
         overflow <= 1'b0;
      end
   end

   // read data stands one cycle only
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= '0;
      end else begin
         O_RDATA <= '0;
         if (I_RD) begin
            case (I_ADDR)
               `DACP_ADDR_MODE: begin
                  O_RDATA[`DACP_BIT_SINGLE] <= single_port_mode;
                  O_RDATA[`DACP_BIT_DATA_CLOCK_EXPORT] <= data_clock_export;
                  O_RDATA[`DACP_BIT_SYNC] <= clock_synchronizer_enable;
                  O_RDATA[`DACP_BIT_IQ_SELECT_POLARITY] <= iq_select_polarity;
               end
               `DACP_ADDR_LOCK: begin
                  O_RDATA[`DACP_BIT_LOCKEXT] <= lock_status_export;
               end
               `DACP_ADDR_STAT: begin
                  O_RDATA[`DACP_ST_LOCK] <= lock_s;
                  O_RDATA[`DACP_ST_OVF] <= overflow;
                  O_RDATA[`DACP_ST_EMPTY] <= !strm.out_valid;
                  O_RDATA[`DACP_ST_FULL] <= !strm.in_ready;
                  O_RDATA[`DACP_ST_PIN_OUT] <= O_SHARED_CLOCK_LOCK_PIN_OE;
               end
               default: begin
                  O_RDATA <= '0;
               end
            endcase
         end
      end
   end

   // divider: double rate clock, data clock at half of it
   assign tick = (div_cnt == HALF_LAST);
   assign dbl_rise = tick && !dbl_int;
   assign dclk_rise = tick && dbl_int && !dclk_int;

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         div_cnt <= '0;
         dbl_int <= 1'b0;
         dclk_int <= 1'b0;
      end else begin
         div_cnt <= tick ? '0 : div_cnt + 1'b1;
         if (tick) begin
            dbl_int <= !dbl_int;
            if (dbl_int) begin
               dclk_int <= !dclk_int;
            end
         end
      end
   end

   // lock export overrides the clock export bit
   always_comb begin
      if (lock_status_export) begin
         pin_mode = DACP_PIN_LOCK_OUT;
      end else if (data_clock_export) begin
         pin_mode = DACP_PIN_CLK_OUT;
      end else begin
         pin_mode = DACP_PIN_IN;
      end
   end

   assign use_pin = (pin_mode == DACP_PIN_IN) && clock_synchronizer_enable;
   // single port words come at twice the data rate
   assign int_ev = single_port_mode ? dbl_rise : dclk_rise;
   assign lat_ev = use_pin ? pin_rise : int_ev;
   // a word is refused while the previous pair still waits for the fifo
   assign take = lat_ev && !push_v;
   assign to_i = iq_select_input ^ iq_select_polarity;

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SHARED_CLOCK_LOCK_PIN <= 1'b0;
         O_SHARED_CLOCK_LOCK_PIN_OE <= 1'b0;
      end else begin
         case (pin_mode)
            DACP_PIN_IN: begin
               O_SHARED_CLOCK_LOCK_PIN <= 1'b0;
               O_SHARED_CLOCK_LOCK_PIN_OE <= 1'b0;
            end
            DACP_PIN_CLK_OUT: begin
               O_SHARED_CLOCK_LOCK_PIN <= dclk_int;
               O_SHARED_CLOCK_LOCK_PIN_OE <= 1'b1;
            end
            DACP_PIN_LOCK_OUT: begin
               O_SHARED_CLOCK_LOCK_PIN <= lock_s;
               O_SHARED_CLOCK_LOCK_PIN_OE <= 1'b1;
            end
            default: begin
               O_SHARED_CLOCK_LOCK_PIN <= 1'b0;
               O_SHARED_CLOCK_LOCK_PIN_OE <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SHARED_DOUBLE_RATE_CLOCK_PIN <= 1'b0;
         O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE <= 1'b0;
      end else begin
         O_SHARED_DOUBLE_RATE_CLOCK_PIN <= single_port_mode && dbl_int;
         O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE <= single_port_mode;
      end
   end

   // word latch, I/Q pairing and push toward the fifo
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pair_st <= DACP_WAIT_I;
         i_hold <= '0;
         push_v <= 1'b0;
         push_i <= '0;
         push_q <= '0;
      end else begin
         if (push_v && strm.in_ready) begin
            push_v <= 1'b0;
         end
         if (!single_port_mode) begin
            pair_st <= DACP_WAIT_I;
            if (take) begin
               push_v <= 1'b1;
               push_i <= port_one_bits;
               push_q <= {iq_select_input, dbl_pin_in, port_two_low_bits};
            end
         end else if (take) begin
            case (pair_st)
               DACP_WAIT_I: begin
                  if (to_i) begin
                     i_hold <= port_one_bits;
                     pair_st <= DACP_WAIT_Q;
                  end
               end
               DACP_WAIT_Q: begin
                  if (to_i) begin
                     i_hold <= port_one_bits;
                  end else begin
                     push_v <= 1'b1;
                     push_i <= i_hold;
                     push_q <= port_one_bits;
                     pair_st <= DACP_WAIT_I;
                  end
               end
               default: begin
                  pair_st <= DACP_WAIT_I;
               end
            endcase
         end
      end
   end

   assign strm.in_valid = push_v;
   assign strm.in_data = {push_i, push_q};
   assign strm.out_ready = !O_WORD_VALID || I_WORD_READY;

   // output stage keeps the stream outputs on flops
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_WORD_VALID <= 1'b0;
         O_I_WORD <= '0;
         O_Q_WORD <= '0;
      end else if (strm.out_ready) begin
         O_WORD_VALID <= strm.out_valid;
         if (strm.out_valid) begin
            O_I_WORD <= strm.out_data[31:16];
            O_Q_WORD <= strm.out_data[15:0];
         end
      end
   end

   // helper: length of each high phase of the double rate output
   logic [7:0] hi_len;
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         hi_len <= '0;
      end else begin
         hi_len <= O_SHARED_DOUBLE_RATE_CLOCK_PIN ? hi_len + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_B);

   sequence s_dual_take;
      take && !single_port_mode;
   endsequence

   sequence s_single_take_i;
      take && single_port_mode && to_i;
   endsequence

   property p_pin_input;
      (pin_mode == DACP_PIN_IN) |=> !O_SHARED_CLOCK_LOCK_PIN_OE;
   endproperty
   a_pin_input: assert property (p_pin_input)
      else $error("shared clock pin driven in input mode");

   property p_sync_off;
      (pin_mode == DACP_PIN_IN && !single_port_mode && !push_v) |=>
         push_v == ($past(clock_synchronizer_enable) ? $past(pin_rise) : $past(dclk_rise));
   endproperty
   a_sync_off: assert property (p_sync_off)
      else $error("latch source does not follow synchronizer bit");

   property p_clk_out;
      (pin_mode == DACP_PIN_CLK_OUT) |=>
         O_SHARED_CLOCK_LOCK_PIN_OE && (O_SHARED_CLOCK_LOCK_PIN == $past(dclk_int));
   endproperty
   a_clk_out: assert property (p_clk_out)
      else $error("data clock not driven on shared pin");

   property p_lock_out;
      (pin_mode == DACP_PIN_LOCK_OUT) |=>
         O_SHARED_CLOCK_LOCK_PIN_OE && (O_SHARED_CLOCK_LOCK_PIN == $past(lock_s));
   endproperty
   a_lock_out: assert property (p_lock_out)
      else $error("lock status not driven on shared pin");

   property p_dual_i;
      s_dual_take |=> push_v && (push_i == $past(port_one_bits));
   endproperty
   a_dual_i: assert property (p_dual_i)
      else $error("port one word not routed to I channel");

   property p_dual_q;
      s_dual_take |=> (push_q[15] == $past(iq_select_input))
         && (push_q[13:0] == $past(port_two_low_bits));
   endproperty
   a_dual_q: assert property (p_dual_q)
      else $error("select pin not Q bit 15");

   property p_route_i;
      s_single_take_i |=> (i_hold == $past(port_one_bits)) && (pair_st == DACP_WAIT_Q);
   endproperty
   a_route_i: assert property (p_route_i)
      else $error("I word not captured");

   property p_route_q;
      (take && single_port_mode && !to_i && pair_st == DACP_WAIT_Q)
         |=> push_v && (push_q == $past(port_one_bits)) && (push_i == $past(i_hold));
   endproperty
   a_route_q: assert property (p_route_q)
      else $error("Q word not paired with held I word");

   property p_bit14;
      s_dual_take |=> (push_q[14] == $past(dbl_pin_in)) && !O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE;
   endproperty
   a_bit14: assert property (p_bit14)
      else $error("double rate pin not Q bit 14 input");

   property p_dbl_rate;
      (single_port_mode && $fell(O_SHARED_DOUBLE_RATE_CLOCK_PIN)
         && $past(O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE, DBL_HALF + 2))
         |-> (hi_len == 8'(DBL_HALF)) && O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE;
   endproperty
   a_dbl_rate: assert property (p_dbl_rate)
      else $error("double rate clock high phase wrong");
endmodule

// >>> testbench/dacp_src_model.sv
// behavioural sample source: framed link clock and data port words
`timescale 1ns/10ps
module dacp_src_model (
   // link clock and data pins
   output logic o_link_clk,
   output logic [15:0] o_port_one_bits,
   output logic [13:0] o_port_two_low_bits,
   output logic o_iq_select,
   output logic o_q_bit14
);
   initial begin
      o_link_clk = 1'b0;
      o_port_one_bits = 16'h0000;
      o_port_two_low_bits = 14'h0000;
      o_iq_select = 1'b0;
      o_q_bit14 = 1'b0;
   end
   // word and select held around the rise
   task automatic send(input logic [15:0] p1, input logic [13:0] p2, input logic sel,
                       input logic b14);
      #17;
      o_port_one_bits = p1;
      o_port_two_low_bits = p2;
      o_iq_select = sel;
      o_q_bit14 = b14;
      // low phase tops up to a 400 ns link period
      #183;
      o_link_clk = 1'b1;
      #200;
      o_link_clk = 1'b0;
      // hold expired: inverse so a late sample cannot match
      o_port_one_bits = ~p1;
      o_port_two_low_bits = ~p2;
      o_iq_select = ~sel;
      o_q_bit14 = ~b14;
   endtask
endmodule

// >>> testbench/dacp_top_tb.sv
// self-checking bench for the data port front end
`timescale 1ns/10ps
`include "dacp_consts.svh"
module dacp_top_tb;
   localparam int HALF = 2;
   logic ref_clk, rst_b, wr_s, rd_s, pll, ready;
   logic [7:0] addr, wdata, rdata, d;
   logic clk_o, clk_oe, dbl_o, dbl_oe, src_clk, src_sel, src_b14;
   logic [15:0] src_p1, i_word, q_word;
   logic [13:0] src_p2;
   logic valid;
   wire clk_pin = clk_oe ? clk_o : src_clk;
   wire dbl_pin = dbl_oe ? dbl_o : src_b14;
   logic [31:0] got[$];
   int failures, checks, cyc, r;

   dacp_top #(.DEPTH(16), .DBL_HALF(HALF)) u_dacp_top (
      .I_REF_CLK(ref_clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_PORT_ONE_BITS(src_p1),
      .I_PORT_TWO_LOW_BITS(src_p2), .I_SHARED_IQ_SELECT_PIN(src_sel),
      .I_SHARED_CLOCK_LOCK_PIN(clk_pin), .O_SHARED_CLOCK_LOCK_PIN(clk_o),
      .O_SHARED_CLOCK_LOCK_PIN_OE(clk_oe), .I_SHARED_DOUBLE_RATE_CLOCK_PIN(dbl_pin),
      .O_SHARED_DOUBLE_RATE_CLOCK_PIN(dbl_o), .O_SHARED_DOUBLE_RATE_CLOCK_PIN_OE(dbl_oe),
      .I_PLL_LOCK(pll), .O_I_WORD(i_word), .O_Q_WORD(q_word), .O_WORD_VALID(valid),
      .I_WORD_READY(ready));

   dacp_src_model u_dacp_src_model (
      .o_link_clk(src_clk), .o_port_one_bits(src_p1), .o_port_two_low_bits(src_p2),
      .o_iq_select(src_sel), .o_q_bit14(src_b14));

   always #25 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (valid === 1'b1 && ready === 1'b1) begin
         got.push_back({i_word, q_word});
      end
   end

   // cut a hang short: whole run needs under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         summarize();
      end
   end

   task automatic summarize();
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic count_rises(input logic dbl, input int n, output int cnt);
      logic prev, cur;
      cnt = 0;
      prev = dbl ? dbl_o : clk_o;
      repeat (n) begin
         cycles(1);
         cur = dbl ? dbl_o : clk_o;
         if (cur === 1'b1 && prev === 1'b0) cnt++;
         prev = cur;
      end
   endtask

   // new mode, flush what the old mode latched
   task automatic mode(input logic [7:0] m);
      wr(`DACP_ADDR_MODE, m);
      cycles(24);
      got.delete();
   endtask

   task automatic wait_pairs(input int n);
      for (int i = 0; i < 300 && got.size() < n; i++) cycles(1);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      pll = 1'b0;
      ready = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(`DACP_ADDR_STAT, d);
      check("status_rst", d, 8'h04);
      rd(`DACP_ADDR_MODE, d);
      check("mode_rst", d, 8'h00);
      rd(8'h10, d);
      check("unmapped", d, 8'h00);
      check("clk_oe_rst", clk_oe, 1'b0);
      check("dbl_oe_rst", dbl_oe, 1'b0);
      ready <= 1'b1;
      mode(8'h04);
      u_dacp_src_model.send(16'h1234, 14'h0abc, 1'b1, 1'b0);
      u_dacp_src_model.send(16'hedcb, 14'h1543, 1'b0, 1'b1);
      wait_pairs(2);
      check("dual_pair0", got[0], 32'h1234_8abc);
      check("dual_pair1", got[1], 32'hedcb_5543);
      got.delete();
      cycles(64);
      check("sync_on_idle", got.size(), 0);
      wr(`DACP_ADDR_MODE, 8'h00);
      cycles(64);
      check("sync_off_runs", got.size() >= 3, 1);
      mode(8'h04);
      wr(`DACP_ADDR_LOCK, 8'h01);
      pll <= 1'b1;
      cycles(8);
      check("lock_oe", clk_oe, 1'b1);
      check("lock_hi", clk_o, 1'b1);
      rd(`DACP_ADDR_STAT, d);
      check("lock_stat", d & 8'h11, 8'h11);
      pll <= 1'b0;
      wr(`DACP_ADDR_MODE, 8'h0c);
      cycles(8);
      check("lock_lo", clk_o, 1'b0);
      count_rises(1'b0, 64, r);
      check("lock_no_clk", r, 0);
      wr(`DACP_ADDR_LOCK, 8'h00);
      cycles(4);
      check("clk_out_oe", clk_oe, 1'b1);
      // data clock period is four half periods of the double rate clock
      count_rises(1'b0, 64, r);
      check("clk_out_rises", r, 64 / (4 * HALF));
      mode(8'h44);
      check("clk_in_oe", clk_oe, 1'b0);
      check("dbl_oe", dbl_oe, 1'b1);
      count_rises(1'b1, 40, r);
      check("dbl_rises", r, 40 / (2 * HALF));
      u_dacp_src_model.send(16'h0001, 14'h0000, 1'b0, 1'b0);
      u_dacp_src_model.send(16'haaaa, 14'h0000, 1'b1, 1'b0);
      u_dacp_src_model.send(16'h5555, 14'h0000, 1'b1, 1'b0);
      u_dacp_src_model.send(16'h0f0f, 14'h0000, 1'b0, 1'b0);
      wait_pairs(1);
      cycles(20);
      check("single_cnt", got.size(), 1);
      check("single_pair", got[0], 32'h5555_0f0f);
      mode(8'h46);
      u_dacp_src_model.send(16'h1111, 14'h0000, 1'b0, 1'b0);
      u_dacp_src_model.send(16'h2222, 14'h0000, 1'b1, 1'b0);
      wait_pairs(1);
      check("inv_pair", got[0], 32'h1111_2222);
      mode(8'h04);
      check("dbl_in_oe", dbl_oe, 1'b0);
      ready <= 1'b0;
      for (int k = 0; k < 20; k++) u_dacp_src_model.send(16'(k), 14'(k), 1'b0, 1'b0);
      cycles(8);
      rd(`DACP_ADDR_STAT, d);
      check("full_ovf", d & 8'h0a, 8'h0a);
      ready <= 1'b1;
      cycles(100);
      // fifo depth plus the output stage plus the pair waiting to push
      check("drained", got.size(), 18);
      for (int k = 0; k < got.size(); k++) check("fill_word", got[k], {k[15:0], k[15:0]});
      wr(`DACP_ADDR_STAT, 8'h02);
      rd(`DACP_ADDR_STAT, d);
      check("status_end", d, 8'h04);
      summarize();
   end
endmodule
